// file: design/dvr_defs.vh
`ifndef DVR_DEFS_VH
`define DVR_DEFS_VH

// System clock rate in Hz
`define DVR_CLK_HZ          24'd10000000
// Identification sample clock rate in Hz
`define DVR_SAMPLE_HZ       24'd3000000
// Reference step clock rate in Hz while slewing
`define DVR_SLEW_HZ         24'd330000
// Width of the fractional tick accumulator
`define DVR_ACC_W           24

// Width of the identification code and of the reference code
`define DVR_CODE_W          8
// Identical consecutive samples needed before a code is accepted
`define DVR_STABLE_READS    2'd3

// Table mode encodings on the mode pins
`define DVR_MODE_W          2
`define DVR_MODE_STEP_A     2'h0
`define DVR_MODE_STEP_B     2'h1
`define DVR_MODE_SLEW_A     2'h2
`define DVR_MODE_SLEW_B     2'h3
// Mode bit that selects the slewing tables
`define DVR_MODE_SLEW_BIT   1

// Reset values
`define DVR_CODE_RST        8'h00
`define DVR_MODE_RST        2'h0

`endif

// file: design/dvr_ref_ctrl.v
`include "dvr_defs.vh"

// Function
// - Sample the identification inputs on every tick of a 3 MHz clock, all modes.
// - Accept a new code only after three consecutive identical samples.
// - Table mode selects direct jump or gradual slewing of the reference.
// - Step-table modes load the reference with the accepted code at once.
// - Slewing-table modes accept changes of more than one step.
// - Slewing-table modes move the reference one step per 330 kHz tick until equal.
module dvr_ref_ctrl (
    input  wire                  i_clk,            // System clock, 10 MHz
    input  wire                  i_sys_rst,        // Synchronous reset, active high
    input  wire [`DVR_CODE_W-1:0] i_voltage_id_code, // Identification pins from processor
    input  wire [`DVR_MODE_W-1:0] i_table_mode,    // Table mode strap pins
    output reg  [`DVR_CODE_W-1:0] o_ref_code,      // Reference code to the converter
    output reg  [`DVR_CODE_W-1:0] o_target_code,   // Last accepted identification code
    output reg                   o_code_accepted,  // Pulse: new code validated
    output reg                   o_slewing,        // Reference still moving to target
    output reg                   o_slew_mode       // Active mode is a slewing table
);

    // Pin synchronisers, three stages each
    reg [`DVR_CODE_W-1:0] vid_s1_r;
    reg [`DVR_CODE_W-1:0] vid_s2_r;
    reg [`DVR_CODE_W-1:0] vid_s3_r;
    reg [`DVR_CODE_W-1:0] vid_pin_r;
    reg [`DVR_MODE_W-1:0] mode_s1_r;
    reg [`DVR_MODE_W-1:0] mode_s2_r;
    reg [`DVR_MODE_W-1:0] mode_s3_r;
    reg [`DVR_MODE_W-1:0] mode_r;

    // Validation state. The run counter saturates rather than wraps,
    // so a code that sits on the pins for a long time is never taken
    // a second time by a counter rollover.
    reg [`DVR_CODE_W-1:0] samp_last_r;
    reg [1:0]             same_cnt_r;
    reg [1:0]             same_cnt_nxt;
    reg                   accept_nxt;

    // Rate enables. Both dividers run free from reset so the sample
    // and step phases are never tied to the moment a code arrives;
    // this costs up to one step period of extra latency on a slew.
    wire                  sample_tick;
    wire                  slew_tick;
    wire                  slew_sel;

    // Sample enable at 3 MHz on average. Ticks fall three or four
    // clocks apart, which gives the spread in validation latency.
    dvr_tick_gen #(
        .RATE_HZ (`DVR_SAMPLE_HZ),
        .CLK_HZ  (`DVR_CLK_HZ)
    ) u_sample_tick (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_tick    (sample_tick)
    );

    // Reference step enable at 330 kHz on average, thirty or
    // thirty-one clocks apart; each tick moves the reference one code.
    dvr_tick_gen #(
        .RATE_HZ (`DVR_SLEW_HZ),
        .CLK_HZ  (`DVR_CLK_HZ)
    ) u_slew_tick (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_tick    (slew_tick)
    );

    // Increment that saturates at the stable-read count
    function [1:0] sat_inc;
        input [1:0] cnt;
        begin
            if (cnt >= `DVR_STABLE_READS)
                sat_inc = `DVR_STABLE_READS;
            else
                sat_inc = cnt + 2'h1;
        end
    endfunction

    // Identification pin synchroniser; a change is taken only when stages
    // two and three agree, so a bus caught mid-transition is never seen.
    // A skew of one clock between pins never passes this test; a wrong value
    // of two clocks or more goes on for the three-sample validation to throw away.
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            vid_s1_r  <= `DVR_CODE_RST;
            vid_s2_r  <= `DVR_CODE_RST;
            vid_s3_r  <= `DVR_CODE_RST;
            vid_pin_r <= `DVR_CODE_RST;
        end
        else
        begin
            vid_s1_r  <= i_voltage_id_code;
            vid_s2_r  <= vid_s1_r;
            vid_s3_r  <= vid_s2_r;
            if (vid_s2_r == vid_s3_r)
                vid_pin_r <= vid_s3_r;
        end
    end

    // Mode strap synchroniser, same agreement test. The straps are meant
    // to be static; a change in use alters how later codes apply and stops or resumes an unfinished slew.
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mode_s1_r <= `DVR_MODE_RST;
            mode_s2_r <= `DVR_MODE_RST;
            mode_s3_r <= `DVR_MODE_RST;
            mode_r    <= `DVR_MODE_RST;
        end
        else
        begin
            mode_s1_r <= i_table_mode;
            mode_s2_r <= mode_s1_r;
            mode_s3_r <= mode_s2_r;
            if (mode_s2_r == mode_s3_r)
                mode_r <= mode_s3_r;
        end
    end

    // Bit one of the mode selects the slewing tables
    assign slew_sel = mode_r[`DVR_MODE_SLEW_BIT];

    // Run-length of identical samples, counted only on sample ticks.
    // A code equal to the present target is never taken again, which
    // also keeps the reset value from being accepted as a new code.
    always @*
    begin
        same_cnt_nxt = same_cnt_r;
        accept_nxt   = 1'b0;
        if (sample_tick)
        begin
            if (vid_pin_r == samp_last_r)
                same_cnt_nxt = sat_inc(same_cnt_r);
            else
                same_cnt_nxt = 2'h1;
            // Any change of code is taken, one step or many
            accept_nxt = (same_cnt_nxt == `DVR_STABLE_READS) &&
                         (vid_pin_r != o_target_code);
        end
    end

    // Validation registers and accepted target. The accept pulse and
    // the new target land on the same edge, so a watcher of the pulse
    // can read the target in that cycle.
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            samp_last_r     <= `DVR_CODE_RST;
            same_cnt_r      <= 2'h0;
            o_target_code   <= `DVR_CODE_RST;
            o_code_accepted <= 1'b0;
        end
        else
        begin
            same_cnt_r      <= same_cnt_nxt;
            o_code_accepted <= accept_nxt;
            if (sample_tick)
                samp_last_r <= vid_pin_r;
            if (accept_nxt)
                o_target_code <= vid_pin_r;
        end
    end

    // Next reference value while slewing: one code toward the target,
    // or hold once equal. It never passes the target, so a retarget
    // that lands behind the present value just turns the direction.
    function [`DVR_CODE_W-1:0] step_toward;
        input [`DVR_CODE_W-1:0] cur;
        input [`DVR_CODE_W-1:0] tgt;
        begin
            if (cur < tgt)
                step_toward = cur + 8'h01;
            else if (cur > tgt)
                step_toward = cur - 8'h01;
            else
                step_toward = cur;
        end
    endfunction

    // Reference update. Step tables jump in the accept cycle; the
    // processor is trusted to move one code at a time there, since a
    // large jump would disturb the converter loop. A mode change does
    // not move the reference by itself; it waits for the next accepted
    // code or step tick.
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_ref_code  <= `DVR_CODE_RST;
            o_slewing   <= 1'b0;
            o_slew_mode <= 1'b0;
        end
        else
        begin
            // Mode flag follows the synchronised strap for watchers
            o_slew_mode <= slew_sel;
            if (!slew_sel)
            begin
                if (accept_nxt)
                    o_ref_code <= vid_pin_r;
                // Step tables never report a slew in progress
                o_slewing <= 1'b0;
            end
            else
            begin
                // Steps from the present value toward the latest target
                if (slew_tick)
                    o_ref_code <= step_toward(o_ref_code, o_target_code);
                // Flag lags the reference by one cycle, which saves a
                // compare on the next value
                o_slewing <= (o_ref_code != o_target_code);
            end
        end
    end

endmodule // dvr_ref_ctrl

// file: design/dvr_tick_gen.v
`include "dvr_defs.vh"

// Fractional divider: emits a one-cycle enable at RATE_HZ on average
// from a CLK_HZ clock. Exact on average, jitter of one clock cycle.
module dvr_tick_gen #(
    parameter [`DVR_ACC_W-1:0] RATE_HZ = `DVR_SAMPLE_HZ,
    parameter [`DVR_ACC_W-1:0] CLK_HZ  = `DVR_CLK_HZ
) (
    input  wire i_clk,      // System clock
    input  wire i_sys_rst,  // Synchronous reset, active high
    output reg  o_tick      // One-cycle enable pulse
);

    reg  [`DVR_ACC_W-1:0] acc_r;
    wire [`DVR_ACC_W:0]   acc_sum;

    // One extra bit so the sum never wraps before the compare
    assign acc_sum = {1'b0, acc_r} + {1'b0, RATE_HZ};

    // Phase accumulator wraps modulo the clock rate
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            acc_r  <= {`DVR_ACC_W{1'b0}};
            o_tick <= 1'b0;
        end
        else if (acc_sum >= {1'b0, CLK_HZ})
        begin
            acc_r  <= acc_sum[`DVR_ACC_W-1:0] - CLK_HZ;
            o_tick <= 1'b1;
        end
        else
        begin
            acc_r  <= acc_sum[`DVR_ACC_W-1:0];
            o_tick <= 1'b0;
        end
    end

endmodule // dvr_tick_gen

// file: tb/dvr_cpu_model.sv
`include "dvr_defs.vh"
module dvr_cpu_model (
    input  wire logic                   i_clk,            // Clock
    input  wire logic [`DVR_CODE_W-1:0] i_req,            // Wanted code
    input  wire logic                   i_one_step,       // Step tables active
    output logic      [`DVR_CODE_W-1:0] o_voltage_id_code // Identification pins
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;
    initial o_voltage_id_code = 8'h00;
    // Step tables get single steps 2.6 us apart, kept slower than the device needs
    always @(posedge i_clk)
    begin
        gap <= gap + 1;
        if (o_voltage_id_code != i_req && (!i_one_step || gap >= 25))
        begin
            gap <= 0;
            if (!i_one_step)
                o_voltage_id_code <= i_req;
            else if (i_req > o_voltage_id_code)
                o_voltage_id_code <= o_voltage_id_code + 8'h01;
            else
                o_voltage_id_code <= o_voltage_id_code - 8'h01;
        end
    end
endmodule // dvr_cpu_model

// file: tb/dvr_ref_ctrl_properties.sv
`include "dvr_defs.vh"
module dvr_ref_ctrl_properties (
    input wire logic                   i_clk,           // Clock
    input wire logic                   i_sys_rst,       // Reset
    input wire logic [`DVR_CODE_W-1:0] o_ref_code,      // Reference
    input wire logic [`DVR_CODE_W-1:0] o_target_code,   // Target
    input wire logic                   o_code_accepted, // Accept pulse
    input wire logic                   o_slewing,       // Slew busy
    input wire logic                   o_slew_mode      // Slew tables
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] gap_r;
    // Cycles since the last step; cleared when idle so a slew start counts from zero
    always @(posedge i_clk)
        gap_r <= (i_sys_rst || !o_slewing || o_ref_code != $past(o_ref_code))
                 ? 8'h00 : gap_r + 8'h01;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    pulse_one_cycle_a: assert property (o_code_accepted |=> !o_code_accepted)
        else $error("accept pulse too long");
    target_hold_a: assert property (!o_code_accepted |-> $stable(o_target_code))
        else $error("target moved without accept");
    accept_new_a: assert property (
        o_code_accepted |-> o_target_code != $past(o_target_code))
        else $error("accept of old code");
    step_jump_a: assert property (
        o_code_accepted && !o_slew_mode |-> o_ref_code == o_target_code)
        else $error("no direct jump");
    step_no_slew_a: assert property (!o_slew_mode |-> !o_slewing)
        else $error("slewing flag in step mode");
    slew_one_step_a: assert property (
        o_slew_mode |-> o_ref_code == $past(o_ref_code)
        || o_ref_code == $past(o_ref_code) + 8'h01 || o_ref_code == $past(o_ref_code) - 8'h01)
        else $error("slew step too big");
    slew_toward_a: assert property (
        o_slew_mode && o_ref_code != $past(o_ref_code) |->
        (o_ref_code > $past(o_ref_code)) == ($past(o_target_code) > $past(o_ref_code)))
        else $error("slew wrong way");
    slew_flag_a: assert property (o_slew_mode && o_ref_code != o_target_code |=> o_slewing)
        else $error("slewing flag low");
    slew_gap_a: assert property (o_slewing |-> gap_r < 8'h24)
        else $error("slew step late");
    cover property (o_code_accepted && !o_slew_mode);
    cover property (o_code_accepted && o_slewing);
    cover property ($fell(o_slewing));
endmodule // dvr_ref_ctrl_properties

// file: tb/test_dvr_ref_ctrl.sv
module test_dvr_ref_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [7:0] req = 8'h00;
    logic [7:0] glitch = 8'h00;
    wire  [7:0] pins;
    wire  [7:0] ref_code;
    wire  [7:0] tgt;
    wire        acc;
    wire        slewing;
    wire        slew_mode;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    int         n;
    always #50 clk = ~clk;
    dvr_cpu_model i_dvr_cpu_model (.i_clk(clk), .i_req(req), .i_one_step(!mode[1]),
        .o_voltage_id_code(pins));
    dvr_ref_ctrl i_dvr_ref_ctrl (.i_clk(clk), .i_sys_rst(sys_rst),
        .i_voltage_id_code(pins ^ glitch), .i_table_mode(mode), .o_ref_code(ref_code),
        .o_target_code(tgt), .o_code_accepted(acc),
        .o_slewing(slewing), .o_slew_mode(slew_mode));
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int lo, input int hi);
        chk({7'h00, n < lo || n > hi}, 8'h00);
    endtask
    task automatic go(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded wait on the reference, or on the accept pulse when v is omitted
    task automatic wait_for(input int lim, input logic [8:0] v = 9'h100);
        n = 0;
        while ((v[8] ? acc !== 1'b1 : ref_code !== v[7:0]) && n < lim)
        begin
            go(1);
            n++;
        end
    endtask
    task automatic t_step;
        mode = 2'h0;
        req = 8'h03;
        wait_for(120, 9'h003);
        chk(tgt, 8'h03);
        chk({7'h00, slewing}, 8'h00);
        chk({7'h00, slew_mode}, 8'h00);
        mode = 2'h1;
        req = 8'h01;
        wait_for(90, 9'h001);
        chk(ref_code, 8'h01);
    endtask
    task automatic t_latency;
        go(30);
        req = 8'h02;
        wait_for(40);
        rng(8, 18);
        chk(ref_code, 8'h02);
    endtask
    task automatic t_glitch;
        go(30);
        glitch = 8'h10;
        go(2);
        glitch = 8'h00;
        wait_for(30);
        rng(30, 30);
        chk(tgt, 8'h02);
    endtask
    task automatic t_slew;
        mode = 2'h2;
        go(5);
        req = 8'h09;
        wait_for(20);
        chk(tgt, 8'h09);
        chk({7'h00, slew_mode}, 8'h01);
        wait_for(300, 9'h009);
        rng(180, 218);
    endtask
    task automatic t_retarget;
        mode = 2'h3;
        go(5);
        req = 8'h01;
        wait_for(200, 9'h006);
        req = 8'h0C;
        wait_for(300, 9'h00C);
        rng(150, 280);
        go(2);
        chk({7'h00, slewing}, 8'h00);
    endtask
    // Runaway guard, well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        go(8);
        sys_rst = 1'b0;
        chk(ref_code | tgt, 8'h00);
        t_step();
        t_latency();
        t_glitch();
        t_slew();
        t_retarget();
        end_sim();
    end
endmodule // test_dvr_ref_ctrl
bind dvr_ref_ctrl dvr_ref_ctrl_properties i_dvr_ref_ctrl_properties (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .o_ref_code(o_ref_code), .o_target_code(o_target_code),
    .o_code_accepted(o_code_accepted), .o_slewing(o_slewing), .o_slew_mode(o_slew_mode));
